// file: cpf_params.svh
// constants of the fault-protected pwm compare channel
// assumes inclusion by bare name from the package and the channel module
`ifndef CPF_PARAMS_SVH
`define CPF_PARAMS_SVH

// compare mode field encodings
`define CPF_MODE_W 3
`define CPF_MODE_PWM 3'b110
`define CPF_MODE_PWM_FLT 3'b111
// fault status position in the channel control register
`define CPF_FAULT_STATUS_BIT 4
// data widths and reset values
`define CPF_DATA_W 16
`define CPF_DUTY_RST 16'h0000
`define CPF_PERIOD_ZERO 16'h0000
// channel grouping of the two fault inputs
`define CPF_GROUP_A_FIRST 1
`define CPF_GROUP_A_LAST 4
`define CPF_GROUP_B_LAST 8
// prescale ratios 1, 8, 64, 256 as terminal counts of the divider
`define CPF_PRE_W 8
`define CPF_PRE_TC_1 8'h00
`define CPF_PRE_TC_8 8'h07
`define CPF_PRE_TC_64 8'h3F
`define CPF_PRE_TC_256 8'hFF

`endif

// file: cpf_pkg.sv
// types shared by the pwm compare channel
// assumes cpf_params.svh is found on the include path
`include "cpf_params.svh"

package cpf_pkg;

  typedef logic [`CPF_DATA_W-1:0] cpf_data_t;
  typedef logic [`CPF_MODE_W-1:0] cpf_mode_t;
  typedef logic [`CPF_PRE_W-1:0] cpf_pre_t;

  // gray coded along off -> run -> fault
  typedef enum logic [1:0] {
    CPF_ST_OFF = 2'b00,
    CPF_ST_RUN = 2'b01,
    CPF_ST_FAULT = 2'b11
  } cpf_state_e;

endpackage

// file: cpf_sync.sv
// two flip-flop synchroniser for one level from outside the clock domain
// assumes the input is a slow level such as a fault pin
module cpf_sync (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // level in and synchronised level out
  input wire logic level_in,
  output logic level_out
);

  typedef struct packed {
    logic meta;
    logic stable;
  } cpf_sync_s;

  cpf_sync_s sync_q;
  cpf_sync_s sync_d;

  // first stage feeds only the second; resets to the inactive (high) level
  always_comb begin
    sync_d = sync_q;
    sync_d.meta = level_in;
    sync_d.stable = sync_q.meta;
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sync_q <= 2'b11;
    end else begin
      sync_q <= sync_d;
    end
  end

  assign level_out = sync_q.stable;

endmodule

// file: cpf_channel.sv
// one compare channel in pwm mode with fault shutdown, plus its time base
// assumes software-side controls arrive as same-clock strobes and levels;
// the fault pins are asynchronous and are synchronised before the flags
//
// Operation
// - mode 111 gives pwm with fault protection enabled
// - fault input a serves channels 1-4, input b serves 5-8
// - low fault level in fault mode tri-states the output pin
// - shutdown path is combinational, never waits for a clock edge
// - tri-state holds until fault high and mode field rewritten
// - fault sets channel interrupt flag, interrupt raised when enabled
// - read-only fault status bit 4 set; clears on fault gone plus rewrite
// - fault inputs keep controlling the pin during sleep or idle
// - period value n gives n+1 prescaled time-base counts
// - buffer copied to active duty only at period match; active read-only
// - active duty zero holds output low
// - active duty above period holds output high
// - duty equal to period gives low for exactly one count
// - in sleep the channel freezes, keeping its output level
// - on wake the channel resumes from the frozen state
// - modes 110 and 111 both select pwm; 110 lacks fault protection
// - period match clears timer, loads duty, drives high unless duty zero; low at duty match
// - timer interrupt flag set at every period boundary
`include "cpf_params.svh"

module cpf_channel
  import cpf_pkg::*;
#(
  parameter int CHANNEL_NUM = 1
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // channel control
  input wire logic [`CPF_MODE_W-1:0] mode_in,
  input wire logic mode_wr_in,
  input wire logic chan_irq_en_in,
  input wire logic chan_flag_clr_in,
  // duty registers
  input wire logic [`CPF_DATA_W-1:0] duty_buf_in,
  input wire logic duty_buf_wr_in,
  input wire logic [`CPF_DATA_W-1:0] duty_init_in,
  input wire logic duty_init_wr_in,
  // time base control
  input wire logic [`CPF_DATA_W-1:0] period_in,
  input wire logic [1:0] prescale_sel_in,
  input wire logic timer_on_in,
  input wire logic timer_flag_clr_in,
  // power state
  input wire logic sleep_in,
  // fault pins, active low, asynchronous
  input wire logic fault_a_n_in,
  input wire logic fault_b_n_in,
  // pin drive
  output logic pwm_level_out,
  output logic pwm_oe_out,
  // status
  output logic [`CPF_MODE_W-1:0] mode_out,
  output logic fault_status_out,
  output logic chan_irq_flag_out,
  output logic chan_irq_out,
  output logic timer_irq_flag_out,
  output logic [`CPF_DATA_W-1:0] active_duty_out,
  output logic [`CPF_DATA_W-1:0] timer_count_out
);

  typedef struct packed {
    cpf_state_e state;
    cpf_mode_t mode;
    cpf_data_t duty_buf;
    cpf_data_t duty;
    cpf_data_t count;
    cpf_pre_t pre_cnt;
    logic level;
    logic drive;
    logic fault;
    logic chan_flag;
    logic chan_irq;
    logic timer_flag;
  } cpf_chan_s;

  cpf_chan_s st_q;
  cpf_chan_s st_d;

  logic fault_raw_n;
  logic fault_sync_n;
  logic pwm_sel;
  logic flt_mode;
  logic tick;
  logic period_match;
  cpf_pre_t pre_tc;
  logic mode_take;
  logic fault_seen;
  logic fault_pin_low;
  logic rearm_ok;

  // channel picks its group's fault pin at elaboration
  assign fault_raw_n = (CHANNEL_NUM <= `CPF_GROUP_A_LAST) ? fault_a_n_in : fault_b_n_in;

  // flags only ever see the synchronised copy
  cpf_sync u_fault_sync (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .level_in(fault_raw_n),
    .level_out(fault_sync_n)
  );

  // mode decode from the stored field
  assign pwm_sel = (st_q.mode == `CPF_MODE_PWM) || (st_q.mode == `CPF_MODE_PWM_FLT);
  assign flt_mode = (st_q.mode == `CPF_MODE_PWM_FLT);

  // a mode write only lands while the clock runs; in sleep it is dropped
  assign mode_take = mode_wr_in && !sleep_in;

  // flag detection sees the synchronised copy only, never the raw pin
  assign fault_seen = flt_mode && !fault_sync_n;

  // raw pin term for the enable gate, kept clear of every flip-flop
  assign fault_pin_low = flt_mode && !fault_raw_n;

  // leaving a fault needs the pin back high and a fresh mode write together
  assign rearm_ok = mode_take && fault_sync_n;

  // prescale ratio select
  always_comb begin
    case (prescale_sel_in)
      2'd0: pre_tc = `CPF_PRE_TC_1;
      2'd1: pre_tc = `CPF_PRE_TC_8;
      2'd2: pre_tc = `CPF_PRE_TC_64;
      default: pre_tc = `CPF_PRE_TC_256;
    endcase
  end

  // one-cycle count enable from the divider; a divider left above a newly
  // lowered terminal count restarts at once instead of wrapping through 256
  assign tick = timer_on_in && (st_q.pre_cnt >= pre_tc);
  assign period_match = (st_q.count == period_in);

  // next-state logic; sleep freezes everything except the state machine, fault capture and the interrupt gate
  always_comb begin
    st_d = st_q;
    if (!sleep_in) begin
      // software side
      if (duty_buf_wr_in) begin
        st_d.duty_buf = duty_buf_in;
      end
      if (duty_init_wr_in && !pwm_sel) begin
        st_d.duty = duty_init_in;
      end
      if (mode_wr_in) begin
        st_d.mode = mode_in;
      end
      // time base: divider then counter
      if (timer_on_in) begin
        st_d.pre_cnt = (st_q.pre_cnt >= pre_tc) ? '0 : st_q.pre_cnt + 1'b1;
      end
      if (tick) begin
        if (period_match) begin
          st_d.count = `CPF_PERIOD_ZERO;
          st_d.timer_flag = 1'b1;
          if (pwm_sel) begin
            st_d.duty = st_q.duty_buf;
          end
        end else begin
          st_d.count = st_q.count + 1'b1;
        end
      end
      if (timer_flag_clr_in && !(tick && period_match)) begin
        st_d.timer_flag = 1'b0;
      end
      // while faulted the level holds; only the enable matters until rearm
      // compare: high below duty, so zero never rises and above-period never falls
      if (pwm_sel && st_q.state != CPF_ST_FAULT) begin
        st_d.level = (st_d.count < st_d.duty);
        st_d.drive = 1'b1;
      end else if (!pwm_sel) begin
        st_d.level = 1'b0;
        st_d.drive = 1'b0;
      end
      if (chan_flag_clr_in) begin
        st_d.chan_flag = 1'b0;
      end
    end
    // channel state machine; fault capture runs even in sleep
    case (st_q.state)
      CPF_ST_OFF: begin
        if (pwm_sel) begin
          st_d.state = CPF_ST_RUN;
        end
      end
      CPF_ST_RUN: begin
        if (!pwm_sel) begin
          st_d.state = CPF_ST_OFF;
        end
      end
      CPF_ST_FAULT: begin
        // leave only on a mode rewrite while the pin is back high
        if (rearm_ok) begin
          st_d.fault = 1'b0;
          st_d.state = CPF_ST_RUN;
        end
      end
      default: begin
        st_d.state = CPF_ST_OFF;
      end
    endcase
    // detection wins over any clear in the same cycle
    if (fault_seen) begin
      st_d.state = CPF_ST_FAULT;
      st_d.fault = 1'b1;
      st_d.chan_flag = 1'b1;
      st_d.drive = 1'b0;
    end
    st_d.chan_irq = st_d.chan_flag && chan_irq_en_in;
  end

  // state register
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // the enable gate must stay combinational so a fault cuts the pin at once
  assign pwm_oe_out = st_q.drive && !fault_pin_low;
  assign pwm_level_out = st_q.level;

  // status views, all straight from the state register
  assign mode_out = st_q.mode;
  assign fault_status_out = st_q.fault;
  assign chan_irq_flag_out = st_q.chan_flag;
  assign chan_irq_out = st_q.chan_irq;
  assign timer_irq_flag_out = st_q.timer_flag;
  assign active_duty_out = st_q.duty;
  assign timer_count_out = st_q.count;

endmodule

// file: cpf_load.sv
// load and fault-sense model at the channel pin
// assumes the bench commands the fault sensor levels
module cpf_load (
  input wire logic level_in,
  input wire logic oe_in,
  input wire logic flt_a_in,
  input wire logic flt_b_in,
  output logic pin_out,
  output logic fault_a_n_out,
  output logic fault_b_n_out
);
  // pull-down gives a safe low while the pin is released
  assign pin_out = oe_in ? level_in : 1'b0;
  // sensors pull the fault lines low when tripped
  assign fault_a_n_out = !flt_a_in;
  assign fault_b_n_out = !flt_b_in;
endmodule

// file: cpf_channel_properties.sv
// assertions on the pwm channel ports
// assumes channel 1, so fault input a governs it
module cpf_channel_properties (
  input wire logic clock_in, rst_in, mode_wr_in, chan_irq_en_in, timer_on_in, sleep_in,
  input wire logic fault_a_n_in, pwm_level_out, pwm_oe_out, fault_status_out,
  input wire logic chan_irq_flag_out, chan_irq_out, timer_irq_flag_out,
  input wire logic [1:0] prescale_sel_in,
  input wire logic [2:0] mode_out,
  input wire logic [15:0] period_in, active_duty_out, timer_count_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // sync fault needs three low samples before the flags may rise
  property p_shut; mode_out == 3'b111 && !fault_a_n_in |-> !pwm_oe_out; endproperty
  a_shut: assert property (p_shut) else $error("no shutdown");
  property p_level; mode_out[2:1] == 2'b11 && $changed(timer_count_out)
    |-> pwm_level_out == (timer_count_out < active_duty_out); endproperty
  a_level: assert property (p_level) else $error("bad level");
  property p_wrap; timer_on_in && !sleep_in && prescale_sel_in == 2'b00
    && timer_count_out == period_in |=> timer_count_out == 16'h0000 && timer_irq_flag_out;
  endproperty
  a_wrap: assert property (p_wrap) else $error("bad wrap");
  property p_ro; mode_out[2:1] == 2'b11 && timer_count_out != period_in
    |=> $stable(active_duty_out); endproperty
  a_ro: assert property (p_ro) else $error("duty moved");
  property p_set; (mode_out == 3'b111 && !fault_a_n_in) [*3]
    |=> fault_status_out && chan_irq_flag_out; endproperty
  a_set: assert property (p_set) else $error("fault not flagged");
  property p_clear; $fell(fault_status_out) |-> $past(mode_wr_in && fault_a_n_in); endproperty
  a_clear: assert property (p_clear) else $error("early clear");
  property p_irq; $rose(chan_irq_flag_out) && $past(chan_irq_en_in) |-> chan_irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("no interrupt");
  property p_sleep; sleep_in |=> $stable(timer_count_out) && $stable(pwm_level_out);
  endproperty
  a_sleep: assert property (p_sleep) else $error("ran in sleep");
  c_fault: cover property ($rose(fault_status_out));
  c_wrap: cover property (timer_irq_flag_out);
  c_sleep: cover property (sleep_in && pwm_level_out);
endmodule
bind cpf_channel cpf_channel_properties cpf_props_inst (.*);

// file: compare_pwm_fault_channel_tb.sv
// bench for the pwm compare channel, channel 1
// assumes prescale 1 and period 3, so one pwm period is 4 cycles
module compare_pwm_fault_channel_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 0, rst_in = 1, mw = 0, bw = 0, iw = 0, ton = 0, slp = 0, fa = 0, fb = 0;
  logic ien = 1, fcl = 0, tclr = 0, tfl;
  logic [1:0] ps = 0;
  logic [2:0] md = 0, mo;
  logic [15:0] buf_v = 0, ini = 0, t, ad, tc;
  logic lvl, oe, pin, fan, fbn, fst, flg, irq, l;
  int errors = 0, n_checks = 0, cyc = 0, hi;
  always #10 clock_in = ~clock_in;
  cpf_load cpf_load_inst (.level_in(lvl), .oe_in(oe), .flt_a_in(fa), .flt_b_in(fb),
    .pin_out(pin), .fault_a_n_out(fan), .fault_b_n_out(fbn));
  cpf_channel cpf_channel_inst (.clock_in, .rst_in, .mode_in(md), .mode_wr_in(mw),
    .chan_irq_en_in(ien), .chan_flag_clr_in(fcl), .duty_buf_in(buf_v), .duty_buf_wr_in(bw),
    .duty_init_in(ini), .duty_init_wr_in(iw), .period_in(16'h0003), .prescale_sel_in(ps),
    .timer_on_in(ton), .timer_flag_clr_in(tclr), .sleep_in(slp), .fault_a_n_in(fan),
    .fault_b_n_in(fbn), .pwm_level_out(lvl), .pwm_oe_out(oe), .mode_out(mo),
    .fault_status_out(fst), .chan_irq_flag_out(flg), .chan_irq_out(irq),
    .timer_irq_flag_out(tfl), .active_duty_out(ad), .timer_count_out(tc));
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  task automatic wr_mode(input logic [2:0] m);
    md = m;
    mw = 1;
    tick(1);
    mw = 0;
    tick(2);
  endtask
  // two periods let the buffer land, then one period is sampled
  task automatic t_duty(input logic [15:0] v, input int n);
    buf_v = v;
    bw = 1;
    tick(1);
    bw = 0;
    tick(8);
    hi = 0;
    repeat (4) begin
      if (lvl === 1'b1) hi++;
      tick(1);
    end
    chk(ad === v && hi == n && oe === 1'b1, "duty");
    $display("duty %0d done", v);
  endtask
  task automatic t_pwm;
    ini = 16'h0002;
    iw = 1;
    tick(1);
    iw = 0;
    chk(ad === 16'h0002, "init duty");
    wr_mode(3'b110);
    ton = 1;
    t_duty(16'h0003, 3);
    t_duty(16'h0000, 0);
    t_duty(16'h0005, 4);
    ini = 16'h0009;
    iw = 1;
    tick(1);
    iw = 0;
    chk(ad === 16'h0005, "init refused");
    chk(tfl === 1'b1, "timer flag");
    // clear with the timer stopped, so no period match can win the cycle
    ton = 0;
    tclr = 1;
    tick(1);
    tclr = 0;
    chk(tfl === 1'b0, "timer flag clear");
    ton = 1;
    fa = 1;
    tick(4);
    chk(oe === 1'b1 && fst === 1'b0, "fault in 110");
    fa = 0;
    // let the synchroniser see the pin high before fault mode is chosen
    tick(3);
    $display("pwm test done");
  endtask
  // fault b must not touch channel 1; fault a trips, holds, then rearms
  task automatic t_fault;
    wr_mode(3'b111);
    fb = 1;
    tick(4);
    chk(oe === 1'b1, "group b");
    fb = 0;
    fa = 1;
    #1;
    chk(oe === 1'b0 && pin === 1'b0, "instant");
    tick(4);
    chk(fst === 1'b1 && flg === 1'b1 && irq === 1'b1, "flags");
    fa = 0;
    tick(3);
    chk(oe === 1'b0 && fst === 1'b1, "hold");
    wr_mode(3'b111);
    chk(oe === 1'b1 && fst === 1'b0, "rearm");
    $display("fault test done");
  endtask
  task automatic t_sleep;
    ien = 0;
    fcl = 1;
    tick(1);
    fcl = 0;
    chk(flg === 1'b0 && irq === 1'b0, "flag clear");
    slp = 1;
    t = tc;
    l = lvl;
    tick(5);
    chk(tc === t && lvl === l, "frozen");
    fa = 1;
    #1;
    chk(oe === 1'b0, "sleep fault");
    tick(4);
    chk(fst === 1'b1 && flg === 1'b1 && irq === 1'b0, "masked flag");
    fa = 0;
    // rewrite only after the synchronised pin is high again
    tick(3);
    slp = 0;
    ien = 1;
    wr_mode(3'b111);
    t = tc;
    tick(1);
    chk(tc !== t && oe === 1'b1, "resume");
    $display("sleep test done");
  endtask
  // prescale 8 stretches each count to eight cycles, then the mode goes off
  task automatic t_pre;
    ps = 2'b01;
    t = tc;
    hi = 0;
    while (tc === t && hi < 20) begin
      tick(1);
      hi++;
    end
    t = tc;
    hi = 0;
    while (tc === t && hi < 20) begin
      tick(1);
      hi++;
    end
    chk(hi == 8, "prescale 8");
    wr_mode(3'b000);
    chk(oe === 1'b0 && mo === 3'b000, "mode off");
    $display("prescale test done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ceiling well above the 110 or so cycles the tests need
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      tally_and_finish();
    end
  end
  initial begin
    tick(2);
    rst_in = 0;
    tick(1);
    chk(oe === 1'b0 && mo === 3'b000 && ad === 16'h0000 && fst === 1'b0, "reset");
    t_pwm();
    t_fault();
    t_sleep();
    t_pre();
    tally_and_finish();
  end
endmodule
